// File: design/bacw_cfg.v
/*
  bus area function and read wait configuration registers with an apb
  slave and a cycle state timer for the external bus.
  assumes presetn is the power-on reset; manual reset arrives
  as a synchronous input and leaves the registers untouched.
*/
// Functional notes
// [RQ1] bus control resets zero, kept otherwise
// [RQ2] bit 15 makes area 1 dram
// [RQ3] bit 14 makes area 6 muxed io
// [RQ4] bit 13 selects normal or warp mode
// [RQ5] bit 12 sets read strobe duty
// [RQ6] bit 11 chooses byte strobe style
// [RQ7] bus control bits 10..0 read zero
// [RQ8] read wait register resets ones, kept otherwise
// [RQ9] bits 15..8 enable wait sampling per area
// [RQ10] areas 1,3,4,5,7: one or three plus wait
// [RQ11] areas 0,2,6: long wait plus optional one
// [RQ12] dram read column pitch from area 1 bit
// [RQ13] refresh uses refresh wait count, no wait
// [RQ14] muxed io reads take four plus wait
// [RQ15] on-chip peripherals read in three states
// [RQ16] on-chip rom and ram read in one
// [RQ17] read wait bits 7..2 and 0 read one
// [RQ18] bit 1 sets dram write column pitch
// [RQ19] software clears bit 1 only in dram mode; the code lets writes clear bit 1 in any mode
// [RQ20] areas 0,2 long wait one to four
// [RQ21] new settings apply from next cycle start
`timescale 1ns/1ns
`default_nettype none
`include "bacw_regs.vh"

module bacw_cfg (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire manual_reset_req,
  input wire cyc_start,
  input wire [2:0] cyc_area,
  input wire cyc_write,
  input wire cyc_refresh,
  input wire cyc_on_chip,
  input wire wait_n,
  input wire [1:0] long_wait_02,
  input wire [1:0] long_wait_6,
  input wire [1:0] refresh_wait,
  output reg cyc_busy,
  output reg cyc_done,
  output reg wait_sample_en,
  output reg area1_dram_select,
  output reg area6_muxed_io_select,
  output reg warp_mode,
  output reg read_strobe_duty_select,
  output reg byte_strobe_style_select
);

  function hit;
    input [11:0] addr;
    input [9:0] idx;
    begin
      hit = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
    end
  endfunction

  function [15:0] merge;
    input [15:0] old;
    input [15:0] wdat;
    input [1:0] lanes;
    input [15:0] wmask;
    begin
      merge = old;
      if (lanes[0]) begin
        merge[7:0] = (old[7:0] & ~wmask[7:0]) | (wdat[7:0] & wmask[7:0]);
      end
      if (lanes[1]) begin
        merge[15:8] = (old[15:8] & ~wmask[15:8]) | (wdat[15:8] & wmask[15:8]);
      end
    end
  endfunction

  reg [15:0] bus_area_function_control_r;
  reg [15:0] read_wait_state_control_r;
  reg [2:0] cnt_r;
  reg [2:0] area_r;
  reg [2:0] cnt_nxt;
  reg busy_nxt;
  reg done_nxt;
  reg samp_nxt;

  wire sel_bcr;
  wire sel_wcr;
  wire sel_st;
  wire mapped;
  wire setup;
  wire wr_acc;
  wire [2:0] calc_states;
  wire calc_sample;
  wire [15:0] bcr_rd;
  wire [15:0] wcr_rd;
  wire [15:0] st_rd;

  assign sel_bcr = hit(paddr, `BACW_IDX_BUS_CTRL);
  assign sel_wcr = hit(paddr, `BACW_IDX_READ_WAIT);
  assign sel_st = hit(paddr, `BACW_IDX_CYC_STATUS);
  assign mapped = sel_bcr | sel_wcr | sel_st;
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pready & pwrite & mapped & ~pslverr;

  assign bcr_rd = bus_area_function_control_r & `BACW_BCR_WMASK; // RQ7
  assign wcr_rd = read_wait_state_control_r | `BACW_READ_WAIT_STATE_CONTROL_ONES; // RQ17
  assign st_rd = {5'h00, area_r, 1'b0, cnt_r, 2'b00, wait_sample_en, cyc_busy};

  // apb answer: ready in the cycle after setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup & (~mapped | (pwrite & sel_st));
      if (setup && !pwrite) begin
        if (sel_bcr) begin
          prdata <= {16'h0000, bcr_rd};
        end else if (sel_wcr) begin
          prdata <= {16'h0000, wcr_rd};
        end else if (sel_st) begin
          prdata <= {16'h0000, st_rd};
        end else begin
          prdata <= 32'h00000000;
        end
      end
    end
  end

  // only power-on reset touches the registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_area_function_control_r <= `BACW_BCR_RESET; // RQ1
      read_wait_state_control_r <= `BACW_READ_WAIT_STATE_CONTROL_RESET; // RQ8
    end else if (wr_acc) begin
      if (sel_bcr) begin
        bus_area_function_control_r <= merge(bus_area_function_control_r,
          pwdata[15:0], pstrb[1:0], `BACW_BCR_WMASK); // RQ7
      end
      if (sel_wcr) begin
        read_wait_state_control_r <= merge(read_wait_state_control_r,
          pwdata[15:0], pstrb[1:0], `BACW_READ_WAIT_STATE_CONTROL_WMASK) | `BACW_READ_WAIT_STATE_CONTROL_ONES; // RQ17
      end
    end
  end

  bacw_state_calc u_calc (
    .area(cyc_area),
    .is_write(cyc_write),
    .is_refresh(cyc_refresh),
    .on_chip(cyc_on_chip),
    .dram_sel(bus_area_function_control_r[`BACW_BIT_DRAM]),
    .muxio_sel(bus_area_function_control_r[`BACW_BIT_MUXIO]),
    .rw_bits(read_wait_state_control_r[`BACW_RW_HI:`BACW_RW_LO]),
    .ww_bit(read_wait_state_control_r[`BACW_BIT_WW1]),
    .long_wait_02(long_wait_02),
    .long_wait_6(long_wait_6),
    .refresh_wait(refresh_wait),
    .states(calc_states),
    .sample(calc_sample)
  );

  // cycle timer: count latched at start, wait extends last state
  always @* begin
    cnt_nxt = cnt_r;
    busy_nxt = cyc_busy;
    done_nxt = 1'b0;
    samp_nxt = wait_sample_en;
    if (manual_reset_req) begin
      cnt_nxt = 3'h0;
      busy_nxt = 1'b0;
      samp_nxt = 1'b0;
    end else if (!cyc_busy) begin
      if (cyc_start) begin
        cnt_nxt = calc_states; // RQ21
        samp_nxt = calc_sample; // RQ9
        busy_nxt = 1'b1;
      end
    end else if (cnt_r > `BACW_ST_ONE) begin
      cnt_nxt = cnt_r - `BACW_ST_ONE;
    end else if (!wait_sample_en || wait_n) begin
      cnt_nxt = 3'h0;
      busy_nxt = 1'b0;
      done_nxt = 1'b1;
      samp_nxt = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 3'h0;
      area_r <= 3'h0;
      cyc_busy <= 1'b0;
      cyc_done <= 1'b0;
      wait_sample_en <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      cyc_busy <= busy_nxt;
      cyc_done <= done_nxt;
      wait_sample_en <= samp_nxt;
      if (!cyc_busy && cyc_start) begin
        area_r <= cyc_area;
      end
    end
  end

  // area function outputs change only between cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      area1_dram_select <= 1'b0;
      area6_muxed_io_select <= 1'b0;
      warp_mode <= 1'b0;
      read_strobe_duty_select <= 1'b0;
      byte_strobe_style_select <= 1'b0;
    end else if (!cyc_busy && !cyc_start) begin
      area1_dram_select <= bus_area_function_control_r[`BACW_BIT_DRAM]; // RQ2
      area6_muxed_io_select <= bus_area_function_control_r[`BACW_BIT_MUXIO]; // RQ3
      warp_mode <= bus_area_function_control_r[`BACW_BIT_WARP]; // RQ4
      read_strobe_duty_select <= bus_area_function_control_r[`BACW_BIT_DUTY]; // RQ5
      byte_strobe_style_select <= bus_area_function_control_r[`BACW_BIT_BSTYLE]; // RQ6
    end
  end

endmodule

`default_nettype wire

// File: design/bacw_regs.vh
/*
  register indices, field positions, reset values and state counts
  of the bus area and read wait configuration block.
  assumes inclusion by bare name from the design files.
*/
`ifndef BACW_REGS_VH
`define BACW_REGS_VH

// register indices, byte address is four times the index
`define BACW_IDX_W 10
`define BACW_IDX_BUS_CTRL 10'h000
`define BACW_IDX_READ_WAIT 10'h001
`define BACW_IDX_CYC_STATUS 10'h002

// bus_area_function_control
`define BACW_BCR_RESET 16'h0000
`define BACW_BCR_WMASK 16'hF800
`define BACW_BIT_DRAM 15
`define BACW_BIT_MUXIO 14
`define BACW_BIT_WARP 13
`define BACW_BIT_DUTY 12
`define BACW_BIT_BSTYLE 11

// read_wait_state_control
`define BACW_READ_WAIT_STATE_CONTROL_RESET 16'hFFFF
`define BACW_READ_WAIT_STATE_CONTROL_WMASK 16'hFF02
`define BACW_READ_WAIT_STATE_CONTROL_ONES 16'h00FD
`define BACW_RW_HI 15
`define BACW_RW_LO 8
`define BACW_BIT_WW1 1

// cycle status fields
`define BACW_ST_BUSY 0
`define BACW_ST_SAMPLE 1
`define BACW_ST_CNT_LO 4
`define BACW_ST_AREA_LO 8

// area numbers
`define BACW_AREA0 3'h0
`define BACW_AREA1 3'h1
`define BACW_AREA2 3'h2
`define BACW_AREA5 3'h5
`define BACW_AREA6 3'h6
`define BACW_AREA7 3'h7

// state counts
`define BACW_ST_ONE 3'h1
`define BACW_ST_TWO 3'h2
`define BACW_ST_THREE 3'h3
`define BACW_ST_FOUR 3'h4
`define BACW_ST_RW_EXTRA 3'h2

`endif

// File: design/bacw_state_calc.v
/*
  combinational count of states for one bus cycle and whether the
  wait input is sampled, from area, space type and configuration.
  assumes all inputs stable while the cycle is being started.
*/
`timescale 1ns/1ns
`default_nettype none
`include "bacw_regs.vh"

module bacw_state_calc (
  input wire [2:0] area,
  input wire is_write,
  input wire is_refresh,
  input wire on_chip,
  input wire dram_sel,
  input wire muxio_sel,
  input wire [7:0] rw_bits,
  input wire ww_bit,
  input wire [1:0] long_wait_02,
  input wire [1:0] long_wait_6,
  input wire [1:0] refresh_wait,
  output reg [2:0] states,
  output reg sample
);

  reg rw_a;
  reg [2:0] lw;

  always @* begin
    rw_a = rw_bits[area];
    lw = (area == `BACW_AREA6) ? ({1'b0, long_wait_6} + `BACW_ST_ONE)
                               : ({1'b0, long_wait_02} + `BACW_ST_ONE); // RQ20
    states = `BACW_ST_ONE;
    sample = 1'b0;
    if (on_chip) begin
      if (area == `BACW_AREA5) begin
        states = `BACW_ST_THREE; // RQ15
      end else begin
        states = `BACW_ST_ONE; // RQ16
      end
    end else if (area == `BACW_AREA1 && dram_sel && is_refresh) begin
      if (rw_a) begin
        states = {1'b0, refresh_wait} + `BACW_ST_ONE; // RQ13
      end
    end else if (area == `BACW_AREA1 && dram_sel) begin
      if (is_write ? ww_bit : rw_a) begin
        states = `BACW_ST_TWO; // RQ12
        sample = 1'b1; // RQ18
      end
    end else if (area == `BACW_AREA1 && is_write) begin
      states = `BACW_ST_TWO;
      sample = 1'b1;
    end else if (area == `BACW_AREA6 && muxio_sel) begin
      states = `BACW_ST_FOUR; // RQ14
      sample = 1'b1;
    end else if (area == `BACW_AREA0 || area == `BACW_AREA2 || area == `BACW_AREA6) begin
      states = rw_a ? (lw + `BACW_ST_TWO) : (lw + `BACW_ST_ONE); // RQ11
      sample = rw_a;
    end else begin
      states = rw_a ? (`BACW_ST_ONE + `BACW_ST_RW_EXTRA) : `BACW_ST_ONE; // RQ10
      sample = rw_a; // RQ9
    end
  end

endmodule

`default_nettype wire

// File: verif/bacw_ext_dev.sv
/* external bus device model
   holds wait_n low for hold cycles of a bus cycle */
`timescale 1ns/1ns
`default_nettype none
module bacw_ext_dev (
  input wire logic pclk,
  input wire logic cyc_busy,
  input wire logic [3:0] hold,
  output logic wait_n
);
  logic [3:0] cnt;
  always @(posedge pclk) cnt <= cyc_busy ? cnt + 4'h1 : 4'h0;
  // pull-up keeps the line high between cycles
  assign wait_n = !(cyc_busy && cnt < hold);
endmodule
`default_nettype wire

// File: verif/bacw_cfg_properties.sv
/* port checker of bacw_cfg
   bound into bacw_cfg, reads only its ports */
`timescale 1ns/1ns
`default_nettype none
module bacw_cfg_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic cyc_start,
  input wire logic [2:0] cyc_area,
  input wire logic cyc_write,
  input wire logic cyc_refresh,
  input wire logic cyc_on_chip,
  input wire logic [1:0] long_wait_02,
  input wire logic cyc_busy,
  input wire logic cyc_done,
  input wire logic wait_sample_en,
  input wire logic area1_dram_select,
  input wire logic area6_muxed_io_select
);
  wire rd_acc = psel && penable && pready && !pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_go; cyc_start && !cyc_busy && !cyc_write && !cyc_refresh; endsequence
  sequence s_one; !wait_sample_en && !cyc_done ##1 cyc_done; endsequence
  property p_bz; rd_acc && paddr == 12'h000 |-> prdata[10:0] == 11'h000; endproperty
  a_bz: assert property (p_bz) else $error("control low bits set");
  property p_wo; rd_acc && paddr == 12'h004 |-> prdata[7:2] == 6'h3F && prdata[0]; endproperty
  a_wo: assert property (p_wo) else $error("wait low bits clear");
  property p_rom; s_go ##0 cyc_on_chip && (cyc_area == 3'h0 || cyc_area == 3'h7) |=> s_one;
  endproperty
  a_rom: assert property (p_rom) else $error("rom ram length");
  property p_per; s_go ##0 cyc_on_chip && cyc_area == 3'h5 |=>
    (!wait_sample_en && !cyc_done)[*3] ##1 cyc_done; endproperty
  a_per: assert property (p_per) else $error("peripheral length");
  property p_mux; s_go ##0 !cyc_on_chip && cyc_area == 3'h6 && area6_muxed_io_select |=>
    (wait_sample_en && !cyc_done)[*4]; endproperty
  a_mux: assert property (p_mux) else $error("muxed io length");
  property p_rw; s_go ##0 !cyc_on_chip && cyc_area == 3'h3 |=>
    (wait_sample_en ##0 (!cyc_done)[*3]) or s_one; endproperty
  a_rw: assert property (p_rw) else $error("area three length");
  property p_lw; s_go ##0 !cyc_on_chip && cyc_area == 3'h2 && long_wait_02 == 2'h0 |=>
    (wait_sample_en ##0 (!cyc_done)[*3]) or (!cyc_done ##1 s_one); endproperty
  a_lw: assert property (p_lw) else $error("long wait length");
  property p_hold; cyc_busy |=> $stable(area1_dram_select) && $stable(area6_muxed_io_select);
  endproperty
  a_hold: assert property (p_hold) else $error("setting moved mid cycle");
endmodule
bind bacw_cfg bacw_cfg_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .cyc_start, .cyc_area, .cyc_write, .cyc_refresh, .cyc_on_chip, .long_wait_02,
  .cyc_busy, .cyc_done, .wait_sample_en, .area1_dram_select, .area6_muxed_io_select);
`default_nettype wire

// File: verif/bacw_cfg_bench.sv
/* self-checking bench of bacw_cfg
   assumes bacw_ext_dev and the bound checker */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %0h got %0h", nm, (e), (g)); end end
module bacw_cfg_bench;
  logic pclk = 1'h0;
  logic presetn, psel, penable, pwrite, pready, pslverr, er, wait_n, wr, rf, oc;
  logic manual_reset_req, cyc_start, cyc_write, cyc_refresh, cyc_on_chip, cyc_busy, cyc_done;
  logic wait_sample_en, area1_dram_select, area6_muxed_io_select, warp_mode;
  logic read_strobe_duty_select, byte_strobe_style_select;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, hold_cycles;
  logic [2:0] cyc_area, a;
  logic [1:0] long_wait_02, long_wait_6, refresh_wait;
  logic [15:0] bcr_m, wcr_m, d;
  logic [4:0] copies;
  int checked = 0, n_mismatch = 0, i;
  assign copies = {area1_dram_select, area6_muxed_io_select, warp_mode,
    read_strobe_duty_select, byte_strobe_style_select};
  bacw_cfg uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .manual_reset_req(manual_reset_req),
    .cyc_start(cyc_start), .cyc_area(cyc_area), .cyc_write(cyc_write),
    .cyc_refresh(cyc_refresh), .cyc_on_chip(cyc_on_chip), .wait_n(wait_n),
    .long_wait_02(long_wait_02), .long_wait_6(long_wait_6), .refresh_wait(refresh_wait),
    .cyc_busy(cyc_busy), .cyc_done(cyc_done), .wait_sample_en(wait_sample_en),
    .area1_dram_select(area1_dram_select), .area6_muxed_io_select(area6_muxed_io_select),
    .warp_mode(warp_mode), .read_strobe_duty_select(read_strobe_duty_select),
    .byte_strobe_style_select(byte_strobe_style_select));
  bacw_ext_dev dev (.pclk(pclk), .cyc_busy(cyc_busy), .hold(hold_cycles), .wait_n(wait_n));
  always #4 pclk = ~pclk;
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(logic w, logic [11:0] ad, logic [15:0] v, logic [3:0] s);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {16'h0000, v};
    pstrb <= s;
    @(posedge pclk) penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr_reg(logic sel, logic [15:0] v, logic [3:0] s);
    logic [15:0] m;
    m = {{8{s[1]}}, {8{s[0]}}};
    apb(1'h1, sel ? 12'h004 : 12'h000, v, s);
    `CHK("write accepted", 1'h0, er)
    if (sel) wcr_m = (wcr_m & ~m) | (v & m);
    else bcr_m = (bcr_m & ~m) | (v & m);
  endtask
  task automatic chk_regs;
    apb(1'h0, 12'h000, 16'h0000, 4'h0);
    `CHK("bus control", ({16'h0000, bcr_m}), rd)
    apb(1'h0, 12'h004, 16'h0000, 4'h0);
    `CHK("read wait", ({16'h0000, wcr_m}), rd)
    `CHK("copies", (bcr_m[15:11]), copies)
  endtask
  function automatic int exp_n(logic [2:0] ar, logic w, logic r, logic o);
    logic rw;
    rw = wcr_m[8 + ar];
    if (o) return ar == 3'h5 ? 3 : 1;
    if (ar == 3'h1 && bcr_m[15] && r) return rw ? int'(refresh_wait) + 1 : 1;
    if (ar == 3'h1 && bcr_m[15]) return (w ? wcr_m[1] : rw) ? 2 : 1;
    if (ar == 3'h1 && w) return 2;
    if (ar == 3'h6 && bcr_m[14]) return 4;
    if (ar == 3'h0 || ar == 3'h2) return long_wait_02 + 2 + rw;
    if (ar == 3'h6) return long_wait_6 + 2 + rw;
    return rw ? 3 : 1;
  endfunction
  task automatic cyc(logic [2:0] ar, logic w, logic r, logic o, logic [3:0] h);
    int n;
    @(posedge pclk);
    cyc_area <= ar;
    cyc_write <= w;
    cyc_refresh <= r;
    cyc_on_chip <= o;
    hold_cycles <= h;
    cyc_start <= 1'h1;
    @(posedge pclk) cyc_start <= 1'h0;
    for (n = 1; n < 60; n++) begin
      @(posedge pclk);
      #1;
      if (cyc_done === 1'h1) break;
    end
    if (h == 4'h0) `CHK("state count", exp_n(ar, w, r, o), n)
    else `CHK("stretched", 1'h1, n > exp_n(ar, w, r, o))
  endtask
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, manual_reset_req, cyc_start,
      cyc_area, cyc_write, cyc_refresh, cyc_on_chip, long_wait_02, long_wait_6,
      refresh_wait, hold_cycles} = '0;
    d = 16'($urandom(32'h3A5AA1E9));
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    bcr_m = 16'h0000;
    wcr_m = 16'hFFFF;
    chk_regs;
    $display("reset test done");
    cyc(3'h3, 1'h0, 1'h0, 1'h0, 4'h6);
    apb(1'h0, 12'h00C, 16'h0000, 4'h0);
    `CHK("unmapped error", 1'h1, er)
    apb(1'h0, 12'h008, 16'h0000, 4'h0);
    `CHK("status idle", 32'h00000300, rd)
    apb(1'h1, 12'h008, 16'hFFFF, 4'h3);
    `CHK("status write refused", 1'h1, er)
    $display("wait and unmapped test done");
    for (i = 0; i < 200; i++) begin
      if (i % 4 == 0) begin
        @(posedge pclk);
        {long_wait_02, long_wait_6, refresh_wait} <= 6'($urandom);
        d = 16'($urandom);
        if (i % 8 == 0) begin
          d = d & 16'hF800;
          d[15] = d[15] | ~wcr_m[1];
        end else begin
          d = d | 16'h00FD;
          d[1] = d[1] | ~bcr_m[15];
        end
        wr_reg(i % 8 != 0, d, 4'($urandom));
        @(posedge pclk) manual_reset_req <= 1'h1;
        @(posedge pclk) manual_reset_req <= 1'h0;
        chk_regs;
      end
      a = 3'($urandom);
      oc = (a == 3'h0 || a == 3'h5 || a == 3'h7) && $urandom % 2;
      wr = !oc && $urandom % 2;
      rf = a == 3'h1 && bcr_m[15] && $urandom % 2;
      cyc(a, wr && !rf, rf, oc, 4'h0);
    end
    $display("random cycle test done");
    @(posedge pclk) presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    bcr_m = 16'h0000;
    wcr_m = 16'hFFFF;
    chk_regs;
    $display("second reset test done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
